//--- rtl/sffr_flash_dev.sv
`timescale 1ns/1ps
module sffr_flash_dev
    import sffr_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    sffr_link_if.device link,
    input wire logic writeInProgress,
    input wire logic memWe,
    input wire logic [MEM_IDX_BITS-1:0] memWaddr,
    input wire logic [7:0] memWdata,
    output logic contMode,
    output logic busy
);
    typedef enum logic [6:0] {
        SFFR_IDLE = 7'h01,
        SFFR_OPC = 7'h02,
        SFFR_ADDR = 7'h04,
        SFFR_MODE = 7'h08,
        SFFR_DUMMY = 7'h10,
        SFFR_DATA = 7'h20,
        SFFR_SKIP = 7'h40
    } sffr_dstate_t;

    logic [7:0] mem [MEM_BYTES];
    logic [2:0] sclkSync_ff;
    logic [1:0] csSync_ff;
    logic [3:0] laneS1_ff;
    logic [3:0] laneS2_ff;
    logic csNs;
    logic rise;
    logic fall;
    logic [3:0] laneIn;

    sffr_dstate_t st_ff, nxt_st;
    sffr_width_t inW_ff, nxt_inW, outW_ff, nxt_outW;
    logic [7:0] sh_ff, nxt_sh;
    logic [5:0] cnt_ff, nxt_cnt;
    logic [23:0] addr_ff, nxt_addr;
    logic [1:0] cont_ff, nxt_cont;
    logic contFour_ff, nxt_contFour;
    logic [7:0] obyte_ff, nxt_obyte;
    logic [3:0] dOut_ff, nxt_dOut;
    logic [3:0] dOe_ff, nxt_dOe;
    logic ioRead_ff, nxt_ioRead;
    logic dOutStart_ff, nxt_dOutStart;
    logic busy_ff, nxt_busy;

    assign csNs = csSync_ff[1];
    assign rise = sclkSync_ff[1] & ~sclkSync_ff[2];
    assign fall = ~sclkSync_ff[1] & sclkSync_ff[2];
    assign laneIn = laneS2_ff;
    assign link.devOut = dOut_ff;
    assign link.devOe = dOe_ff;
    assign contMode = cont_ff[0];
    assign busy = busy_ff;

    always_ff @(posedge mclk) begin
        sclkSync_ff <= {sclkSync_ff[1:0], link.sclk};
        csSync_ff <= {csSync_ff[0], link.csN};
        laneS1_ff <= link.lane;
        laneS2_ff <= laneS1_ff;
        if (memWe) begin
            mem[memWaddr] <= memWdata;
        end
    end

    function automatic logic [7:0] shiftIn(input logic [7:0] s,
        input logic [3:0] l, input sffr_width_t w);
        case (w)
            SFFR_W2: shiftIn = {s[5:0], l[1], l[0]};
            SFFR_W4: shiftIn = {s[3:0], l};
            default: shiftIn = {s[6:0], l[0]};
        endcase
    endfunction : shiftIn

    function automatic logic [3:0] laneBits(input logic [7:0] b,
        input sffr_width_t w);
        case (w)
            SFFR_W2: laneBits = {2'h0, b[7], b[6]};
            SFFR_W4: laneBits = b[7:4];
            default: laneBits = {2'h0, b[7], 1'h0};
        endcase
    endfunction : laneBits

    function automatic logic [3:0] laneEn(input sffr_width_t w);
        case (w)
            SFFR_W2: laneEn = 4'h3;
            SFFR_W4: laneEn = 4'hF;
            default: laneEn = 4'h2;
        endcase
    endfunction : laneEn

    always_comb begin
        logic [7:0] sIn;
        logic [5:0] perByte;
        logic [7:0] rdByte;
        logic [7:0] b;
        sIn = shiftIn(sh_ff, laneIn, inW_ff);
        b = obyte_ff;
        perByte = {1'h0, sffr_bits_per_clk(inW_ff)};
        rdByte = mem[addr_ff[MEM_IDX_BITS-1:0]];
        nxt_st = st_ff;
        nxt_inW = inW_ff;
        nxt_outW = outW_ff;
        nxt_sh = sh_ff;
        nxt_cnt = cnt_ff;
        nxt_addr = addr_ff;
        nxt_cont = cont_ff;
        nxt_contFour = contFour_ff;
        nxt_obyte = obyte_ff;
        nxt_dOut = dOut_ff;
        nxt_dOe = dOe_ff;
        nxt_ioRead = ioRead_ff;
        nxt_dOutStart = 1'h0;
        if (csNs) begin
            nxt_st = SFFR_IDLE;
            nxt_dOe = 4'h0;
        end else begin
            case (st_ff)
                SFFR_IDLE: begin
                    nxt_cnt = 6'h00;
                    nxt_sh = 8'h00;
                    if (writeInProgress) begin
                        nxt_st = SFFR_SKIP;
                    end else if (cont_ff[0]) begin
                        // Opcode omitted, address comes at once
                        nxt_st = SFFR_ADDR;
                        nxt_ioRead = 1'h1;
                        nxt_inW = contFour_ff ? SFFR_W4 : SFFR_W2;
                        nxt_outW = nxt_inW;
                    end else begin
                        nxt_st = SFFR_OPC;
                        nxt_inW = SFFR_W1;
                    end
                end
                SFFR_OPC: if (rise) begin
                    nxt_sh = sIn;
                    nxt_cnt = cnt_ff + 6'h01;
                    if (cnt_ff == 6'h07) begin
                        nxt_cnt = 6'h00;
                        nxt_st = SFFR_ADDR;
                        nxt_ioRead = 1'h0;
                        case (sIn)
                            OP_QUICK_READ: nxt_outW = SFFR_W1;
                            OP_TWO_OUT: nxt_outW = SFFR_W2;
                            OP_FOUR_OUT: nxt_outW = SFFR_W4;
                            OP_TWO_IO: begin
                                nxt_inW = SFFR_W2;
                                nxt_outW = SFFR_W2;
                                nxt_ioRead = 1'h1;
                            end
                            OP_FOUR_IO: begin
                                nxt_inW = SFFR_W4;
                                nxt_outW = SFFR_W4;
                                nxt_ioRead = 1'h1;
                            end
                            OP_MODE_RESET: begin
                                nxt_cont = 2'h0;
                                nxt_st = SFFR_SKIP;
                            end
                            default: nxt_st = SFFR_SKIP;
                        endcase
                    end
                end
                SFFR_ADDR: if (rise) begin
                    if (inW_ff == SFFR_W1) begin
                        nxt_addr = {addr_ff[22:0], laneIn[0]};
                    end else if (inW_ff == SFFR_W2) begin
                        nxt_addr = {addr_ff[21:0], laneIn[1], laneIn[0]};
                    end else begin
                        nxt_addr = {addr_ff[19:0], laneIn};
                    end
                    nxt_cnt = cnt_ff + perByte;
                    if (cnt_ff + perByte == 6'd24) begin
                        nxt_cnt = 6'h00;
                        nxt_st = ioRead_ff ? SFFR_MODE : SFFR_DUMMY;
                    end
                end
                SFFR_MODE: if (rise) begin
                    nxt_sh = sIn;
                    nxt_cnt = cnt_ff + perByte;
                    if (cnt_ff + perByte == 6'd8) begin
                        nxt_cnt = 6'h00;
                        // Low nibble ignored
                        nxt_cont[0] =
                            (sIn[7:4] == MODE_KEEP_NIBBLE);
                        nxt_contFour = (inW_ff == SFFR_W4);
                        nxt_st = (inW_ff == SFFR_W4) ? SFFR_DUMMY : SFFR_DATA;
                        nxt_dOutStart = (inW_ff == SFFR_W2);
                    end
                end
                SFFR_DUMMY: if (rise) begin
                    // Lane values here are never looked at
                    nxt_cnt = cnt_ff + 6'h01;
                    if (cnt_ff == (ioRead_ff ? 6'(DUMMY_CLKS_FOUR_IO - 1)
                        : 6'(DUMMY_CLKS_SINGLE - 1))) begin
                        nxt_cnt = 6'h00;
                        nxt_st = SFFR_DATA;
                        nxt_dOutStart = 1'h1;
                    end
                end
                SFFR_DATA: begin
                    if (dOutStart_ff) begin
                        nxt_obyte = rdByte;
                        nxt_cnt = 6'h00;
                    end else if (fall) begin
                        nxt_dOut = laneBits(b, outW_ff);
                        nxt_dOe = laneEn(outW_ff);
                        nxt_obyte = b << sffr_bits_per_clk(outW_ff);
                        nxt_cnt = cnt_ff + {1'h0, sffr_bits_per_clk(outW_ff)};
                        if (cnt_ff + {1'h0, sffr_bits_per_clk(outW_ff)}
                            == 6'd8) begin
                            nxt_cnt = 6'h00;
                            nxt_addr = addr_ff + 24'h1;
                            if (addr_ff[ADDR_BITS-1:0] == '1) begin
                                nxt_addr = 24'(ADDR_RESET);
                            end
                            nxt_dOutStart = 1'h1;
                        end
                    end
                end
                SFFR_SKIP: nxt_dOe = 4'h0;
                default: nxt_st = SFFR_IDLE;
            endcase
        end
        nxt_busy = (nxt_st != SFFR_IDLE);
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            st_ff <= SFFR_IDLE;
            inW_ff <= SFFR_W1;
            outW_ff <= SFFR_W1;
            sh_ff <= 8'h00;
            cnt_ff <= 6'h00;
            addr_ff <= 24'h000000;
            cont_ff <= 2'h0;
            contFour_ff <= 1'h0;
            obyte_ff <= 8'h00;
            dOut_ff <= 4'h0;
            dOe_ff <= 4'h0;
            ioRead_ff <= 1'h0;
            dOutStart_ff <= 1'h0;
            busy_ff <= 1'h0;
        end else begin
            st_ff <= nxt_st;
            inW_ff <= nxt_inW;
            outW_ff <= nxt_outW;
            sh_ff <= nxt_sh;
            cnt_ff <= nxt_cnt;
            addr_ff <= nxt_addr;
            cont_ff <= nxt_cont;
            contFour_ff <= nxt_contFour;
            obyte_ff <= nxt_obyte;
            dOut_ff <= nxt_dOut;
            dOe_ff <= nxt_dOe;
            ioRead_ff <= nxt_ioRead;
            dOutStart_ff <= nxt_dOutStart;
            busy_ff <= nxt_busy;
        end
    end
endmodule : sffr_flash_dev

//--- rtl/sffr_pkg.sv
package sffr_pkg;
    localparam logic [7:0] OP_QUICK_READ = 8'h0B;
    localparam logic [7:0] OP_TWO_OUT = 8'h3B;
    localparam logic [7:0] OP_TWO_IO = 8'hBB;
    localparam logic [7:0] OP_FOUR_OUT = 8'h6B;
    localparam logic [7:0] OP_FOUR_IO = 8'hEB;
    localparam logic [7:0] OP_MODE_RESET = 8'hFF;
    localparam logic [3:0] MODE_KEEP_NIBBLE = 4'hA;
    localparam logic [7:0] MODE_BYTE_KEEP = 8'hA0;
    localparam logic [7:0] MODE_BYTE_LEAVE = 8'h00;
    localparam int ADDR_BITS = 22;
    localparam logic [21:0] ADDR_RESET = 22'h000000;
    localparam int DUMMY_CLKS_SINGLE = 8;
    localparam int DUMMY_CLKS_FOUR_IO = 4;
    localparam int LINK_DIV_HALF = 8;
    localparam int MEM_BYTES = 1024;
    localparam int MEM_IDX_BITS = 10;
    typedef enum logic [2:0] {
        SFFR_W1 = 3'h1,
        SFFR_W2 = 3'h2,
        SFFR_W4 = 3'h4
    } sffr_width_t;
    function automatic logic [4:0] sffr_bits_per_clk(input sffr_width_t w);
        case (w)
            SFFR_W2: sffr_bits_per_clk = 5'h02;
            SFFR_W4: sffr_bits_per_clk = 5'h04;
            default: sffr_bits_per_clk = 5'h01;
        endcase
    endfunction : sffr_bits_per_clk
endpackage : sffr_pkg

//--- rtl/sffr_link_if.sv
`timescale 1ns/1ps
interface sffr_link_if;
    logic sclk;
    logic csN;
    logic [3:0] hostOut;
    logic [3:0] hostOe;
    logic [3:0] devOut;
    logic [3:0] devOe;
    logic [3:0] lane;
    assign lane = (hostOut & hostOe) | (devOut & devOe)
        | ~(hostOe | devOe);
    modport host (output sclk, output csN, output hostOut, output hostOe,
        input lane);
    modport device (input sclk, input csN, output devOut, output devOe,
        input lane);
endinterface : sffr_link_if

//--- rtl/sffr_spi_host.sv
`timescale 1ns/1ps
module sffr_spi_host
    import sffr_pkg::*;
(
    input wire logic mclk,
    input wire logic srst,
    sffr_link_if.host link,
    input wire logic start,
    input wire logic [7:0] opcode,
    input wire logic useOpcode,
    input wire logic [23:0] startAddr,
    input wire logic [7:0] modeByte,
    input wire logic [7:0] byteCount,
    output logic [7:0] rdData,
    output logic rdValid,
    output logic done,
    output logic idle
);
    typedef enum logic [6:0] {
        SFFRH_IDLE = 7'h01,
        SFFRH_OPC = 7'h02,
        SFFRH_ADDR = 7'h04,
        SFFRH_MODE = 7'h08,
        SFFRH_DUMMY = 7'h10,
        SFFRH_DATA = 7'h20,
        SFFRH_END = 7'h40
    } sffr_hstate_t;

    sffr_hstate_t st_ff, nxt_st;
    sffr_width_t inW_ff, nxt_inW, outW_ff, nxt_outW;
    logic [3:0] div_ff, nxt_div;
    logic sclk_ff, nxt_sclk;
    logic cs_ff, nxt_cs;
    logic [31:0] sh_ff, nxt_sh;
    logic [5:0] cnt_ff, nxt_cnt;
    logic [7:0] left_ff, nxt_left;
    logic [7:0] rx_ff, nxt_rx;
    logic [3:0] out_ff, nxt_out;
    logic [3:0] oe_ff, nxt_oe;
    logic [7:0] rd_ff, nxt_rd;
    logic rv_ff, nxt_rv;
    logic done_ff, nxt_done;
    logic [1:0] io_ff, nxt_io;
    logic mr_ff, nxt_mr;
    logic [3:0] ls1_ff, ls2_ff;

    assign link.sclk = sclk_ff;
    assign link.csN = cs_ff;
    assign link.hostOut = out_ff;
    assign link.hostOe = oe_ff;
    assign rdData = rd_ff;
    assign rdValid = rv_ff;
    assign done = done_ff;
    assign idle = st_ff[0];

    always_ff @(posedge mclk) begin
        ls1_ff <= link.lane;
        ls2_ff <= ls1_ff;
    end

    always_comb begin
        logic tick;
        logic [5:0] bpc;
        logic [5:0] ob;
        tick = (div_ff == 4'(LINK_DIV_HALF - 1));
        bpc = {1'h0, sffr_bits_per_clk(inW_ff)};
        ob = {1'h0, sffr_bits_per_clk(outW_ff)};
        nxt_st = st_ff;
        nxt_inW = inW_ff;
        nxt_outW = outW_ff;
        nxt_div = tick ? 4'h0 : div_ff + 4'h1;
        nxt_sclk = sclk_ff;
        nxt_cs = cs_ff;
        nxt_sh = sh_ff;
        nxt_cnt = cnt_ff;
        nxt_left = left_ff;
        nxt_rx = rx_ff;
        nxt_out = out_ff;
        nxt_oe = oe_ff;
        nxt_rd = rd_ff;
        nxt_rv = 1'h0;
        nxt_done = 1'h0;
        nxt_io = io_ff;
        nxt_mr = mr_ff;
        case (st_ff)
            SFFRH_IDLE: begin
                nxt_sclk = 1'h0;
                nxt_oe = 4'h0;
                if (start) begin
                    nxt_cs = 1'h0;
                    nxt_div = 4'h0;
                    nxt_left = byteCount;
                    nxt_cnt = 6'h00;
                    nxt_io = {opcode == OP_FOUR_IO, opcode == OP_TWO_IO
                        || opcode == OP_FOUR_IO};
                    nxt_outW = (opcode == OP_TWO_OUT || opcode == OP_TWO_IO)
                        ? SFFR_W2 : (opcode == OP_FOUR_OUT
                        || opcode == OP_FOUR_IO) ? SFFR_W4 : SFFR_W1;
                    nxt_inW = (opcode == OP_TWO_IO) ? SFFR_W2
                        : (opcode == OP_FOUR_IO) ? SFFR_W4 : SFFR_W1;
                    nxt_mr = useOpcode && (opcode == OP_MODE_RESET);
                    // First unit goes out now, ahead of the first rise
                    if (useOpcode) begin
                        nxt_st = SFFRH_OPC;
                        nxt_inW = SFFR_W1;
                        nxt_sh = {opcode[6:0], 25'h0000000};
                        nxt_out = {3'h0, opcode[7]};
                        nxt_oe = 4'h1;
                    end else begin
                        nxt_st = SFFRH_ADDR;
                        nxt_sh = {startAddr, 8'h00}
                            << sffr_bits_per_clk(nxt_inW);
                        nxt_out = laneOut(startAddr[23:20], nxt_inW);
                        nxt_oe = laneEnH(nxt_inW);
                    end
                end
            end
            default: if (tick) begin
                nxt_sclk = ~sclk_ff;
                if (sclk_ff) begin
                    // Falling edge: host changes its lanes
                    if (st_ff == SFFRH_END) begin
                        // Frame closes with the link clock low
                        nxt_st = SFFRH_IDLE;
                        nxt_cs = 1'h1;
                        nxt_done = 1'h1;
                        nxt_oe = 4'h0;
                    end else if (st_ff != SFFRH_DATA
                        && st_ff != SFFRH_DUMMY) begin
                        nxt_oe = laneEnH(inW_ff);
                        nxt_out = laneOut(sh_ff[31:28], inW_ff);
                        nxt_sh = sh_ff << bpc[2:0];
                    end else begin
                        nxt_oe = 4'h0;
                    end
                end else begin
                    nxt_cnt = cnt_ff + bpc;
                    case (st_ff)
                        SFFRH_OPC: if (cnt_ff == 6'h07) begin
                            nxt_cnt = 6'h00;
                            // Mode reset sends no address, only idle ones
                            nxt_st = mr_ff ? SFFRH_DUMMY : SFFRH_ADDR;
                            nxt_sh = {startAddr, 8'h00};
                            nxt_inW = io_ff[1] ? SFFR_W4 : io_ff[0]
                                ? SFFR_W2 : SFFR_W1;
                        end
                        SFFRH_ADDR: if (cnt_ff + bpc == 6'd24) begin
                            nxt_cnt = 6'h00;
                            nxt_st = io_ff[0] ? SFFRH_MODE : SFFRH_DUMMY;
                            nxt_sh = {modeByte, 24'h000000};
                        end
                        SFFRH_MODE: if (cnt_ff + bpc == 6'd8) begin
                            nxt_cnt = 6'h00;
                            nxt_st = io_ff[1] ? SFFRH_DUMMY : SFFRH_DATA;
                        end
                        SFFRH_DUMMY: begin
                            nxt_cnt = cnt_ff + 6'h01;
                            if (cnt_ff == (io_ff[1]
                                ? 6'(DUMMY_CLKS_FOUR_IO - 1)
                                : 6'(DUMMY_CLKS_SINGLE - 1))) begin
                                nxt_cnt = 6'h00;
                                nxt_st = mr_ff ? SFFRH_END : SFFRH_DATA;
                            end
                        end
                        SFFRH_DATA: begin
                            nxt_cnt = cnt_ff + ob;
                            case (outW_ff)
                                SFFR_W2: nxt_rx = {rx_ff[5:0], ls2_ff[1:0]};
                                SFFR_W4: nxt_rx = {rx_ff[3:0], ls2_ff};
                                default: nxt_rx = {rx_ff[6:0], ls2_ff[1]};
                            endcase
                            if (cnt_ff + ob == 6'd8) begin
                                nxt_cnt = 6'h00;
                                nxt_rd = nxt_rx;
                                nxt_rv = 1'h1;
                                nxt_left = left_ff - 8'h01;
                                if (left_ff == 8'h01) begin
                                    nxt_st = SFFRH_END;
                                end
                            end
                        end
                        default: nxt_st = SFFRH_IDLE;
                    endcase
                end
            end
        endcase
    end

    function automatic logic [3:0] laneEnH(input sffr_width_t w);
        case (w)
            SFFR_W2: laneEnH = 4'h3;
            SFFR_W4: laneEnH = 4'hF;
            default: laneEnH = 4'h1;
        endcase
    endfunction : laneEnH

    function automatic logic [3:0] laneOut(input logic [3:0] t,
        input sffr_width_t w);
        case (w)
            SFFR_W2: laneOut = {2'h0, t[3], t[2]};
            SFFR_W4: laneOut = t;
            default: laneOut = {3'h0, t[3]};
        endcase
    endfunction : laneOut

    always_ff @(posedge mclk) begin
        if (srst) begin
            st_ff <= SFFRH_IDLE;
            inW_ff <= SFFR_W1;
            outW_ff <= SFFR_W1;
            div_ff <= 4'h0;
            sclk_ff <= 1'h0;
            cs_ff <= 1'h1;
            sh_ff <= 32'h00000000;
            cnt_ff <= 6'h00;
            left_ff <= 8'h00;
            rx_ff <= 8'h00;
            out_ff <= 4'h0;
            oe_ff <= 4'h0;
            rd_ff <= 8'h00;
            rv_ff <= 1'h0;
            done_ff <= 1'h0;
            io_ff <= 2'h0;
            mr_ff <= 1'h0;
        end else begin
            st_ff <= nxt_st;
            inW_ff <= nxt_inW;
            outW_ff <= nxt_outW;
            div_ff <= nxt_div;
            sclk_ff <= nxt_sclk;
            cs_ff <= nxt_cs;
            sh_ff <= nxt_sh;
            cnt_ff <= nxt_cnt;
            left_ff <= nxt_left;
            rx_ff <= nxt_rx;
            out_ff <= nxt_out;
            oe_ff <= nxt_oe;
            rd_ff <= nxt_rd;
            rv_ff <= nxt_rv;
            done_ff <= nxt_done;
            io_ff <= nxt_io;
            mr_ff <= nxt_mr;
        end
    end
endmodule : sffr_spi_host

//--- testbench/sffr_checker.sv
`timescale 1ns/1ps
module sffr_checker (
    input wire logic mclk,
    input wire logic srst,
    input wire logic sclk,
    input wire logic csN,
    input wire logic [3:0] hostOut,
    input wire logic [3:0] hostOe,
    input wire logic [3:0] devOut,
    input wire logic [3:0] devOe,
    input wire logic [3:0] lane
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (srst);
    property p_dev_quiet_idle;
        csN [*8] |-> devOe == 4'h0;
    endproperty
    a_dev_quiet_idle: assert property (p_dev_quiet_idle)
        else $error("device drives while deselected");
    property p_no_fight;
        (hostOe & devOe) == 4'h0;
    endproperty
    a_no_fight: assert property (p_no_fight)
        else $error("host and device drive one lane");
    property p_dev_late_start;
        $fell(csN) |-> (devOe == 4'h0) [*8];
    endproperty
    a_dev_late_start: assert property (p_dev_late_start)
        else $error("device drives during opcode");
    property p_sclk_idle;
        csN |-> !sclk;
    endproperty
    a_sclk_idle: assert property (p_sclk_idle)
        else $error("link clock not idle low");
    property p_sclk_period;
        $rose(sclk) |=> (!$rose(sclk)) [*8];
    endproperty
    a_sclk_period: assert property (p_sclk_period)
        else $error("link clock too fast");
    // Device lags the fall by its synchronisers, still inside low half
    property p_dev_moves_low;
        !csN && $changed(devOut & devOe) |-> !sclk;
    endproperty
    a_dev_moves_low: assert property (p_dev_moves_low)
        else $error("device output moved while clock high");
    property p_host_moves_low;
        !csN && $changed(hostOut & hostOe) |-> !sclk;
    endproperty
    a_host_moves_low: assert property (p_host_moves_low)
        else $error("host output moved while clock high");
    property p_frame_holds;
        $fell(csN) |=> (!csN) [*8];
    endproperty
    a_frame_holds: assert property (p_frame_holds)
        else $error("frame ended at once");
endmodule : sffr_checker

//--- testbench/serial_flash_fast_read_path_tb.sv
`timescale 1ns/1ps
module serial_flash_fast_read_path_tb;
    import sffr_pkg::*;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic start = 1'b0;
    logic [7:0] opcode = 8'h00;
    logic useOpcode = 1'b1;
    logic [23:0] startAddr = 24'h000000;
    logic [7:0] modeByte = 8'h00;
    logic [7:0] byteCount = 8'h01;
    logic writeInProgress = 1'b0;
    logic memWe = 1'b0;
    logic [MEM_IDX_BITS-1:0] memWaddr = '0;
    logic [7:0] memWdata = 8'h00;
    logic [7:0] rdData;
    logic rdValid, done, idle, contMode, busy;
    int err_total = 0;
    int check_count = 0;
    sffr_link_if u_link ();
    sffr_spi_host u_sffr_spi_host (.mclk(mclk), .srst(srst), .link(u_link),
        .start(start), .opcode(opcode), .useOpcode(useOpcode),
        .startAddr(startAddr), .modeByte(modeByte), .byteCount(byteCount),
        .rdData(rdData), .rdValid(rdValid), .done(done), .idle(idle));
    sffr_flash_dev u_sffr_flash_dev (.mclk(mclk), .srst(srst),
        .link(u_link), .writeInProgress(writeInProgress), .memWe(memWe),
        .memWaddr(memWaddr), .memWdata(memWdata), .contMode(contMode),
        .busy(busy));
    sffr_checker u_sffr_checker (.mclk(mclk), .srst(srst),
        .sclk(u_link.sclk), .csN(u_link.csN), .hostOut(u_link.hostOut),
        .hostOe(u_link.hostOe), .devOut(u_link.devOut),
        .devOe(u_link.devOe), .lane(u_link.lane));
    initial begin
        forever #5 mclk = ~mclk;
    end
    function automatic logic [7:0] pat(input int i);
        pat = i[7:0] ^ {i[9:8], 6'h15};
    endfunction : pat
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask : chk
    // Skipped frames read the pulled-up lanes, so all ones
    task automatic rd(input logic [7:0] op, input logic uo,
            input logic [23:0] a, input logic [7:0] m, input int n,
            input logic skip);
        int w;
        opcode = op;
        useOpcode = uo;
        startAddr = a;
        modeByte = m;
        byteCount = n[7:0];
        start = 1'b1;
        #10;
        start = 1'b0;
        for (int k = 0; k < n; k++) begin
            w = 0;
            while (rdValid !== 1'b1 && w < 900) begin
                #10;
                w++;
            end
            chk({7'h00, rdValid}, 8'h01);
            chk(rdData, skip ? 8'hFF
                : pat((int'(a[9:0]) + k) % MEM_BYTES));
            #10;
        end
        w = 0;
        while (done !== 1'b1 && w < 900) begin
            #10;
            w++;
        end
        chk({7'h00, done}, 8'h01);
        #100;
        chk({7'h00, busy}, 8'h00);
        chk({7'h00, idle}, 8'h01);
    endtask : rd
    task automatic t_single();
        rd(OP_QUICK_READ, 1'b1, 24'hFFFFFE, 8'h00, 4, 1'b0);
        rd(OP_TWO_OUT, 1'b1, 24'hC00123, 8'h00, 6, 1'b0);
        rd(OP_FOUR_OUT, 1'b1, 24'h0003FD, 8'h00, 5, 1'b0);
        $display("single-lane header reads done");
    endtask : t_single
    task automatic t_two_io();
        rd(OP_TWO_IO, 1'b1, 24'h000040, 8'hA5, 3, 1'b0);
        chk({7'h00, contMode}, 8'h01);
        rd(OP_TWO_IO, 1'b0, 24'h3FFFFF, 8'hA0, 2, 1'b0);
        // Mode reset frame carries no data bytes
        rd(OP_MODE_RESET, 1'b1, 24'h000000, 8'h00, 0, 1'b1);
        chk({7'h00, contMode}, 8'h00);
        rd(OP_QUICK_READ, 1'b1, 24'h000077, 8'h00, 2, 1'b0);
        $display("two-lane continuous reads done");
    endtask : t_two_io
    task automatic t_four_io();
        rd(OP_FOUR_IO, 1'b1, 24'h000200, 8'hAF, 3, 1'b0);
        chk({7'h00, contMode}, 8'h01);
        rd(OP_FOUR_IO, 1'b0, 24'h000300, 8'h00, 2, 1'b0);
        chk({7'h00, contMode}, 8'h00);
        $display("four-lane continuous reads done");
    endtask : t_four_io
    task automatic t_wip();
        writeInProgress = 1'b1;
        rd(OP_FOUR_IO, 1'b1, 24'h000010, 8'hA0, 2, 1'b1);
        chk({7'h00, contMode}, 8'h00);
        writeInProgress = 1'b0;
        $display("busy-array reads done");
    endtask : t_wip
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : report_and_stop
    initial begin
        repeat (16) @(posedge mclk);
        #1;
        srst = 1'b0;
        memWe = 1'b1;
        for (int i = 0; i < MEM_BYTES; i++) begin
            memWaddr = i[MEM_IDX_BITS-1:0];
            memWdata = pat(i);
            #10;
        end
        memWe = 1'b0;
        t_single();
        t_two_io();
        t_four_io();
        t_wip();
        report_and_stop();
    end
    initial begin
        #600us;
        err_total++;
        report_and_stop();
    end
endmodule : serial_flash_fast_read_path_tb
